// ### hw/bsl_top.sv
// Boot strap latch, boot mode decode and power-on control sequencing
`timescale 1ns/1ps
`include "bsl_defines.svh"
module bsl_top #(
  parameter int unsigned HOLD_CYCLES = `BSL_HOLD_CYC,
  parameter int unsigned TMR_W = `BSL_TMR_W
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  // Power-on control pin, high runs the chip
  input wire logic I_CHIP_EN,
  // Reset causes that recapture the straps
  input wire logic I_WDT_RST,
  input wire logic I_BROWNOUT_RST,
  // Print message policy from fuses
  input wire logic [1:0] I_FUSE_POLICY,
  // Print strap pin
  input wire logic I_PRINT_STRAP_PIN_IN,
  output logic O_PRINT_STRAP_PIN_OUT,
  output logic O_PRINT_STRAP_PIN_OE_N,
  // Boot strap pin
  input wire logic I_BOOT_STRAP_PIN_IN,
  input wire logic I_BOOT_STRAP_PIN_FLOAT,
  output logic O_BOOT_STRAP_PIN_OUT,
  output logic O_BOOT_STRAP_PIN_OE_N,
  output logic O_BOOT_STRAP_PULLUP_EN,
  // Decoded results
  output logic O_CHIP_RUN,
  output logic O_STRAP_VALID,
  output logic [1:0] O_BOOT_MODE,
  output logic O_PRINT_EN,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA
);

  bsl_pkg::bsl_state_e state_q;
  bsl_pkg::bsl_state_e state_d;
  bsl_pkg::bsl_boot_e boot_mode;
  logic reset_req;
  logic capture;
  logic hold_done;
  logic running;
  logic print_en;
  logic print_strap_q;
  logic boot_strap_q;
  logic [1:0] fuse_q;
  logic valid_q;
  logic boot_sample;
  logic boot_capture;
  logic print_on;
  logic [TMR_W-1:0] hold_load;
  logic [`BSL_GPIO_W-1:0] gpio_q;
  logic print_out_q;
  logic print_oe_n_q;
  logic boot_out_q;
  logic boot_oe_n_q;
  logic pullup_en_q;
  logic rd_en;
  logic [`BSL_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [`BSL_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;

  // Register bus front end
  bsl_ahb_slave #(
    .ADDR_W(`BSL_ADDR_W)
  ) u_ahb (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_hsel(I_HSEL),
    .i_haddr(I_HADDR),
    .i_htrans(I_HTRANS),
    .i_hwrite(I_HWRITE),
    .i_hsize(I_HSIZE),
    .i_hwdata(I_HWDATA),
    .i_hready(I_HREADY),
    .o_hreadyout(O_HREADYOUT),
    .o_hresp(O_HRESP),
    .o_hrdata(O_HRDATA),
    .o_rd_en(rd_en),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data)
  );

  // Window length cut to the timer width
  assign hold_load = TMR_W'(HOLD_CYCLES);

  // Hold window timer after each capture
  bsl_timer #(
    .CNT_W(TMR_W)
  ) u_hold (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_start(capture),
    .i_load(hold_load),
    .o_done(hold_done)
  );

  // Reset causes, whether or not the chip is enabled
  assign reset_req = I_WDT_RST || I_BROWNOUT_RST;

  // Capture on power-on, watchdog or brownout reset
  always_comb begin
    capture = 1'b0;
    if (I_CHIP_EN) begin
      if (state_q == bsl_pkg::BSL_OFF) begin
        capture = 1'b1;
      end else if (reset_req) begin
        capture = 1'b1;
      end
    end
  end

  // Next state of the power sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      bsl_pkg::BSL_OFF: begin
        if (I_CHIP_EN) begin
          state_d = bsl_pkg::BSL_HOLD;
        end
      end
      bsl_pkg::BSL_HOLD: begin
        if (!I_CHIP_EN) begin
          state_d = bsl_pkg::BSL_OFF;
        end else if (hold_done && !reset_req) begin
          state_d = bsl_pkg::BSL_RUN;
        end
      end
      bsl_pkg::BSL_RUN: begin
        if (!I_CHIP_EN) begin
          state_d = bsl_pkg::BSL_OFF;
        end else if (reset_req) begin
          state_d = bsl_pkg::BSL_HOLD;
        end
      end
      default: begin
        state_d = bsl_pkg::BSL_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_q <= bsl_pkg::BSL_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Chip runs only with enable high and the hold window over
  assign running = (state_q == bsl_pkg::BSL_RUN);
  assign O_CHIP_RUN = running;

  // Floating boot strap reads high through the pull-up
  assign boot_sample = I_BOOT_STRAP_PIN_IN || (I_BOOT_STRAP_PIN_FLOAT && pullup_en_q);

  // Pull-up counts as on at every capture, a reset restores its default
  assign boot_capture = I_BOOT_STRAP_PIN_IN || I_BOOT_STRAP_PIN_FLOAT;

  // Strap latches, loaded only on a capture
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      print_strap_q <= `BSL_STRAP_RST;
      boot_strap_q <= `BSL_STRAP_RST;
      fuse_q <= `BSL_FUSE_RST;
    end else if (capture) begin
      print_strap_q <= I_PRINT_STRAP_PIN_IN;
      boot_strap_q <= boot_capture;
      fuse_q <= I_FUSE_POLICY;
    end
  end

  // Latched bits valid from capture until shutdown
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      valid_q <= 1'b0;
    end else if (!I_CHIP_EN) begin
      valid_q <= 1'b0;
    end else if (capture) begin
      valid_q <= 1'b1;
    end
  end

  // Boot mode from the held strap bits
  always_comb begin
    if (!valid_q) begin
      boot_mode = bsl_pkg::BSL_BOOT_NONE;
    end else if (boot_strap_q) begin
      boot_mode = bsl_pkg::BSL_BOOT_FLASH;
    end else if (print_strap_q) begin
      boot_mode = bsl_pkg::BSL_BOOT_LOAD;
    end else begin
      boot_mode = bsl_pkg::BSL_BOOT_INVALID;
    end
  end

  // Print enable from the latched policy and print strap
  always_comb begin
    case (fuse_q)
      `BSL_POL_ALWAYS: print_en = 1'b1;
      `BSL_POL_ON_LOW: print_en = !print_strap_q;
      `BSL_POL_ON_HIGH: print_en = print_strap_q;
      default: print_en = 1'b0;
    endcase
  end

  // Decoded results gated by the valid flag
  assign print_on = valid_q && print_en;
  assign O_BOOT_MODE = boot_mode;
  assign O_PRINT_EN = print_on;
  assign O_STRAP_VALID = valid_q;

  // Pin control register written by software
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      gpio_q <= `BSL_GPIO_RST;
    end else if (wr_en && (wr_addr == `BSL_OFF_GPIO_CTRL)) begin
      gpio_q <= wr_data[`BSL_GPIO_W-1:0];
    end
  end

  // Print strap pin released to normal use only while running
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      print_out_q <= 1'b0;
      print_oe_n_q <= 1'b1;
    end else if (running) begin
      print_out_q <= gpio_q[`BSL_GPIO_PRINT_OUT_BIT];
      print_oe_n_q <= !gpio_q[`BSL_GPIO_PRINT_OE_BIT];
    end else begin
      print_out_q <= 1'b0;
      print_oe_n_q <= 1'b1;
    end
  end

  // Boot strap pin released to normal use only while running
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      boot_out_q <= 1'b0;
      boot_oe_n_q <= 1'b1;
    end else if (running) begin
      boot_out_q <= gpio_q[`BSL_GPIO_BOOT_OUT_BIT];
      boot_oe_n_q <= !gpio_q[`BSL_GPIO_BOOT_OE_BIT];
    end else begin
      boot_out_q <= 1'b0;
      boot_oe_n_q <= 1'b1;
    end
  end

  // Pull-up forced on outside run and on a reset request, software may drop it in run
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pullup_en_q <= 1'b1;
    end else if (running && !reset_req) begin
      pullup_en_q <= !gpio_q[`BSL_GPIO_PULLUP_DIS_BIT];
    end else begin
      pullup_en_q <= 1'b1;
    end
  end

  // Pin controls toward the pads
  assign O_PRINT_STRAP_PIN_OUT = print_out_q;
  assign O_PRINT_STRAP_PIN_OE_N = print_oe_n_q;
  assign O_BOOT_STRAP_PIN_OUT = boot_out_q;
  assign O_BOOT_STRAP_PIN_OE_N = boot_oe_n_q;
  assign O_BOOT_STRAP_PULLUP_EN = pullup_en_q;

  // Read decode, unmapped reads return zero
  always_comb begin
    rd_data = `BSL_RDATA_RST;
    if (!rd_en) begin
      rd_data = `BSL_RDATA_RST;
    end else if (rd_addr == `BSL_OFF_STRAP) begin
      rd_data[`BSL_STRAP_PRINT_BIT] = print_strap_q;
      rd_data[`BSL_STRAP_BOOT_BIT] = boot_strap_q;
    end else if (rd_addr == `BSL_OFF_POLICY) begin
      rd_data[`BSL_POL_LATCH_MSB:`BSL_POL_LATCH_LSB] = fuse_q;
      rd_data[`BSL_POL_LIVE_MSB:`BSL_POL_LIVE_LSB] = I_FUSE_POLICY;
    end else if (rd_addr == `BSL_OFF_STATUS) begin
      rd_data[`BSL_STAT_MODE_MSB:`BSL_STAT_MODE_LSB] = boot_mode;
      rd_data[`BSL_STAT_PRINT_EN_BIT] = print_on;
      rd_data[`BSL_STAT_STATE_MSB:`BSL_STAT_STATE_LSB] = state_q;
      rd_data[`BSL_STAT_VALID_BIT] = valid_q;
    end else if (rd_addr == `BSL_OFF_GPIO_CTRL) begin
      rd_data[`BSL_GPIO_W-1:0] = gpio_q;
    end else if (rd_addr == `BSL_OFF_PIN_IN) begin
      rd_data[`BSL_STRAP_PRINT_BIT] = I_PRINT_STRAP_PIN_IN;
      rd_data[`BSL_STRAP_BOOT_BIT] = boot_sample;
    end else begin
      rd_data = `BSL_RDATA_RST;
    end
  end

endmodule : bsl_top

// ### include/bsl_defines.svh
// Constants for the boot strap latch and enable block
// Functional notes
// - Both strap pin levels are captured on power-on, RTC watchdog and brownout resets.
// - Captured strap bits stay fixed until the next reset or power-down, whatever the pins do later.
// - The boot strap pin has a weak pull-up by default, so a floating pin latches as 1.
// - Boot strap 1 selects flash boot; boot strap 0 with print strap 1 selects image-load boot.
// - Print policy 0 always prints, 1 prints on print strap 0, 2 on print strap 1, 3 never.
// - After reset both strap pins return to ordinary pin use while the latched bits stay in force.
// - Both latched strap bits are readable by software in one register field.
// - Power-on control high lets the chip run; low holds it off.
`ifndef BSL_DEFINES_SVH
`define BSL_DEFINES_SVH

// Register byte offsets
`define BSL_ADDR_W 8
`define BSL_OFF_STRAP 8'h00
`define BSL_OFF_POLICY 8'h04
`define BSL_OFF_STATUS 8'h08
`define BSL_OFF_GPIO_CTRL 8'h0C
`define BSL_OFF_PIN_IN 8'h10

// Field positions
`define BSL_STRAP_PRINT_BIT 0
`define BSL_STRAP_BOOT_BIT 1
`define BSL_GPIO_PRINT_OUT_BIT 0
`define BSL_GPIO_BOOT_OUT_BIT 1
`define BSL_GPIO_PRINT_OE_BIT 2
`define BSL_GPIO_BOOT_OE_BIT 3
`define BSL_GPIO_PULLUP_DIS_BIT 4
`define BSL_GPIO_W 5
`define BSL_STAT_PRINT_EN_BIT 2
`define BSL_STAT_VALID_BIT 5

// Multi-bit field ranges
`define BSL_POL_LATCH_MSB 1
`define BSL_POL_LATCH_LSB 0
`define BSL_POL_LIVE_MSB 3
`define BSL_POL_LIVE_LSB 2
`define BSL_STAT_MODE_MSB 1
`define BSL_STAT_MODE_LSB 0
`define BSL_STAT_STATE_MSB 4
`define BSL_STAT_STATE_LSB 3

// Reset values
`define BSL_GPIO_RST 5'h00
`define BSL_STRAP_RST 1'b0
`define BSL_FUSE_RST 2'h0
`define BSL_RDATA_RST 32'h0000_0000

// Fuse policy codes
`define BSL_POL_ALWAYS 2'h0
`define BSL_POL_ON_LOW 2'h1
`define BSL_POL_ON_HIGH 2'h2
`define BSL_POL_NEVER 2'h3

// AHB encodings
`define BSL_HSIZE_WORD 3'h2
`define BSL_HRESP_OKAY 1'b0

// Timing: strap hold window after power-on control rises
`define BSL_CLK_KHZ 50000
`define BSL_HOLD_TIME_MS 3
`define BSL_HOLD_CYC (`BSL_HOLD_TIME_MS * `BSL_CLK_KHZ)
`define BSL_TMR_W 18

`endif

// ### include/bsl_pkg.sv
// Types for the boot strap latch and enable block
package bsl_pkg;

  // Power and reset sequence states
  typedef enum logic [1:0] {
    BSL_OFF  = 2'b00,
    BSL_HOLD = 2'b01,
    BSL_RUN  = 2'b10
  } bsl_state_e;

  // Decoded boot modes
  typedef enum logic [1:0] {
    BSL_BOOT_NONE    = 2'b00,
    BSL_BOOT_FLASH   = 2'b01,
    BSL_BOOT_LOAD    = 2'b10,
    BSL_BOOT_INVALID = 2'b11
  } bsl_boot_e;

endpackage : bsl_pkg

// ### hw/bsl_timer.sv
// Down counter timing the strap hold window
`timescale 1ns/1ps
module bsl_timer #(
  parameter int unsigned CNT_W = 18
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_load,
  output logic o_done
);

  logic [CNT_W-1:0] cnt_q;

  // Load on start, then count down to zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_start) begin
      cnt_q <= i_load;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // Last cycle of the window
  assign o_done = !i_start && (cnt_q == CNT_W'(1));

endmodule : bsl_timer

// ### hw/bsl_ahb_slave.sv
// AHB-Lite slave front end with zero wait states
`timescale 1ns/1ps
`include "bsl_defines.svh"
module bsl_ahb_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_rd_en,
  output logic [ADDR_W-1:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  output logic o_wr_en,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [31:0] o_wr_data
);

  logic addr_ok;
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;

  // Valid word transfer in the address phase
  assign addr_ok = i_hsel && i_htrans[1] && i_hready && (i_hsize == `BSL_HSIZE_WORD);

  // Write address held into the data phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_ok && i_hwrite;
      if (addr_ok && i_hwrite) begin
        wr_addr_q <= i_haddr[ADDR_W-1:0];
      end
    end
  end

  // Read data registered for the data phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hrdata_q <= `BSL_RDATA_RST;
    end else if (o_rd_en) begin
      hrdata_q <= i_rd_data;
    end
  end

  // Strobes toward the register file
  assign o_rd_en = addr_ok && !i_hwrite;
  assign o_rd_addr = i_haddr[ADDR_W-1:0];
  assign o_wr_en = wr_pend_q;
  assign o_wr_addr = wr_addr_q;
  assign o_wr_data = i_hwdata;
  assign o_hrdata = hrdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = `BSL_HRESP_OKAY;

endmodule : bsl_ahb_slave

// ### sim/bsl_checker.sv
// Port checker for the boot strap latch block
`timescale 1ns/1ps
module bsl_checker #(
  parameter int unsigned HOLD_CYCLES = 8
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CHIP_EN,
  input wire logic I_WDT_RST,
  input wire logic I_BROWNOUT_RST,
  input wire logic [1:0] I_FUSE_POLICY,
  input wire logic I_PRINT_STRAP_PIN_IN,
  input wire logic I_BOOT_STRAP_PIN_IN,
  input wire logic I_BOOT_STRAP_PIN_FLOAT,
  input wire logic O_PRINT_STRAP_PIN_OE_N,
  input wire logic O_BOOT_STRAP_PIN_OE_N,
  input wire logic O_BOOT_STRAP_PULLUP_EN,
  input wire logic O_CHIP_RUN,
  input wire logic O_STRAP_VALID,
  input wire logic [1:0] O_BOOT_MODE,
  input wire logic O_PRINT_EN,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP
);
  logic [1:0] md_x;
  logic pe_x;
  int hold_q;
  wire logic [1:0] pol = I_FUSE_POLICY;
  wire logic p = I_PRINT_STRAP_PIN_IN;
  // Expected decode of the pins now
  assign md_x = (I_BOOT_STRAP_PIN_FLOAT | I_BOOT_STRAP_PIN_IN) ? 2'h1 : (p ? 2'h2 : 2'h3);
  assign pe_x = (pol == 2'h0) | (pol == 2'h1 & !p) | (pol == 2'h2 & p);
  // Cycles spent in the hold window
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_WDT_RST || I_BROWNOUT_RST || O_CHIP_RUN || !O_STRAP_VALID) begin
      hold_q <= 0;
    end else begin
      hold_q <= hold_q + 1;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus not ready or not okay");
  chk_capture_mode: assert property ($rose(I_CHIP_EN) |=> O_STRAP_VALID && O_BOOT_MODE == $past(md_x))
    else $error("boot mode wrong after capture");
  chk_pullup_float: assert property ($rose(I_CHIP_EN) && I_BOOT_STRAP_PIN_FLOAT |=> O_BOOT_MODE == 2'h1)
    else $error("floating boot pin not read as one");
  chk_print_policy: assert property ($rose(I_CHIP_EN) |=> O_PRINT_EN == $past(pe_x))
    else $error("print enable wrong");
  chk_recapture: assert property (I_CHIP_EN && O_STRAP_VALID && (I_WDT_RST || I_BROWNOUT_RST)
    |=> !O_CHIP_RUN && O_BOOT_MODE == $past(md_x))
    else $error("recapture wrong");
  chk_latch_stable: assert property (O_STRAP_VALID && $past(O_STRAP_VALID) && !$past(I_WDT_RST)
    && !$past(I_BROWNOUT_RST) |-> $stable(O_BOOT_MODE) && $stable(O_PRINT_EN))
    else $error("latched decode changed");
  chk_off_low: assert property (!I_CHIP_EN |=> !O_CHIP_RUN && !O_STRAP_VALID && O_BOOT_MODE == 2'h0)
    else $error("chip not held off");
  chk_hold_window: assert property ($rose(O_CHIP_RUN) |-> hold_q == int'(HOLD_CYCLES))
    else $error("hold window length wrong");
  chk_pins_released: assert property (!O_CHIP_RUN && !$past(O_CHIP_RUN)
    |-> O_PRINT_STRAP_PIN_OE_N && O_BOOT_STRAP_PIN_OE_N && O_BOOT_STRAP_PULLUP_EN)
    else $error("strap pins driven outside run");
  cover property ($rose(O_CHIP_RUN));
  cover property (I_BROWNOUT_RST && O_CHIP_RUN);
  cover property (O_STRAP_VALID && O_BOOT_MODE == 2'h2);
endmodule : bsl_checker

bind bsl_top bsl_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_CHIP_EN(I_CHIP_EN), .I_WDT_RST(I_WDT_RST), .I_BROWNOUT_RST(I_BROWNOUT_RST),
  .I_FUSE_POLICY(I_FUSE_POLICY), .I_PRINT_STRAP_PIN_IN(I_PRINT_STRAP_PIN_IN),
  .I_BOOT_STRAP_PIN_IN(I_BOOT_STRAP_PIN_IN), .I_BOOT_STRAP_PIN_FLOAT(I_BOOT_STRAP_PIN_FLOAT),
  .O_PRINT_STRAP_PIN_OE_N(O_PRINT_STRAP_PIN_OE_N), .O_BOOT_STRAP_PIN_OE_N(O_BOOT_STRAP_PIN_OE_N),
  .O_BOOT_STRAP_PULLUP_EN(O_BOOT_STRAP_PULLUP_EN), .O_CHIP_RUN(O_CHIP_RUN), .O_STRAP_VALID(O_STRAP_VALID),
  .O_BOOT_MODE(O_BOOT_MODE), .O_PRINT_EN(O_PRINT_EN), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP));

// ### sim/bsl_host_model.sv
// Host model driving power-on control and strap pins
`timescale 1ns/1ps
module bsl_host_model #(
  parameter int unsigned EN_LOW_CYC = 2500
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_on,
  input wire logic i_drive,
  input wire logic i_print,
  input wire logic i_boot,
  input wire logic i_float,
  output logic o_chip_en,
  output logic o_print_pin,
  output logic o_boot_pin,
  output logic o_boot_float
);
  int low_q;
  // Low time of power-on control, counted from rails up
  always_ff @(posedge i_clk) begin
    if (i_rst || (o_chip_en && !i_on)) begin
      low_q <= 0;
    end else if (!i_on && low_q < int'(EN_LOW_CYC)) begin
      low_q <= low_q + 1;
    end
  end
  // Raise only after the minimum low time
  always_ff @(posedge i_clk) begin
    o_chip_en <= !i_rst && i_on && low_q >= int'(EN_LOW_CYC);
  end
  // Straps driven on request, else both pins toggle each cycle and o_boot_float is set
  always_ff @(posedge i_clk) begin
    if (i_drive) begin
      o_print_pin <= i_print | !(i_boot | i_float);
      o_boot_pin <= i_boot;
      o_boot_float <= i_float;
    end else begin
      o_print_pin <= !o_print_pin;
      o_boot_pin <= !o_boot_pin;
      o_boot_float <= 1'b1;
    end
  end
endmodule : bsl_host_model

// ### sim/boot_strap_latch_and_enable_test.sv
// Self-checking bench for the boot strap latch block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module boot_strap_latch_and_enable_test;
  logic clk, rst, on, drv, prt, bt, flt, wdt, bro, hsel, hwr;
  logic dph = 1'b0;
  logic [1:0] fuse, htr, mode;
  logic [31:0] had, hwd, hrd, ex;
  logic [31:0] q[$];
  wire logic ce, pp, bp, bf, rdy, resp, run, vld, pe, po, poe, bo, boe, pu;
  wire logic ppw = poe ? pp : po;
  int miscompares = 0;
  int n_tests = 0;
  bsl_host_model host (.i_clk(clk), .i_rst(rst), .i_on(on), .i_drive(drv), .i_print(prt), .i_boot(bt),
    .i_float(flt), .o_chip_en(ce), .o_print_pin(pp), .o_boot_pin(bp), .o_boot_float(bf));
  bsl_top #(.HOLD_CYCLES(8)) uut (.I_CLK(clk), .I_RST(rst), .I_CHIP_EN(ce), .I_WDT_RST(wdt),
    .I_BROWNOUT_RST(bro), .I_FUSE_POLICY(fuse), .I_PRINT_STRAP_PIN_IN(ppw), .O_PRINT_STRAP_PIN_OUT(po),
    .O_PRINT_STRAP_PIN_OE_N(poe), .I_BOOT_STRAP_PIN_IN(bp), .I_BOOT_STRAP_PIN_FLOAT(bf),
    .O_BOOT_STRAP_PIN_OUT(bo), .O_BOOT_STRAP_PIN_OE_N(boe), .O_BOOT_STRAP_PULLUP_EN(pu),
    .O_CHIP_RUN(run), .O_STRAP_VALID(vld), .O_BOOT_MODE(mode), .O_PRINT_EN(pe), .I_HSEL(hsel),
    .I_HADDR(had), .I_HTRANS(htr), .I_HWRITE(hwr), .I_HSIZE(3'h2), .I_HWDATA(hwd), .I_HREADY(rdy),
    .O_HREADYOUT(rdy), .O_HRESP(resp), .O_HRDATA(hrd));
  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    hwr <= w;
    had <= {24'h0, a};
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, $urandom);
  endtask : rd
  // Power cycle with given straps and policy
  task automatic pwr(input logic p, input logic b, input logic f, input logic [1:0] pol);
    logic eb;
    logic ep;
    on <= 1'b0;
    drv <= 1'b1;
    prt <= p;
    bt <= b;
    flt <= f;
    fuse <= pol;
    cyc(2510);
    on <= 1'b1;
    while (run !== 1'b1) cyc(1);
    drv <= 1'b0;
    fuse <= ~pol;
    eb = b | f;
    ep = (pol == 2'h0) | (pol == 2'h1 & !p) | (pol == 2'h2 & p);
    rd(8'h00, {30'h0, eb, p});
    rd(8'h04, {28'h0, ~pol, pol});
    rd(8'h08, {27'h1, 2'h2, ep, eb ? 2'h1 : 2'h2});
  endtask : pwr
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Read data checked against the oldest note
  always @(posedge clk) begin
    if (dph && rdy) begin
      ex = q.pop_front();
      `CHK("hrdata", ex, hrd)
    end
    if (rdy) dph <= hsel && htr[1] && !hwr;
  end
  initial begin
    cyc(40000);
    miscompares++;
    give_verdict();
  end
  initial begin
    {rst, drv, prt, bt} = 4'hF;
    {on, flt, wdt, bro, hsel, hwr} = 6'h0;
    {fuse, htr, had, hwd} = 68'h0;
    void'($urandom(33));
    cyc(10);
    rst <= 1'b0;
    rd(8'h20 + 8'($urandom_range(7)) * 8'h4, 32'h0);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 8; i++) begin
      pwr(i[2], i[1] | !i[2], i[0], i[1:0]);
    end
    bus(1'b1, 8'h0C, 32'h17);
    cyc(2);
    `CHK("print_oe_n", 1'b0, poe)
    `CHK("print_out", 1'b1, po)
    `CHK("boot_oe_n", 1'b1, boe)
    `CHK("boot_out", 1'b1, bo)
    `CHK("pullup", 1'b0, pu)
    rd(8'h0C, 32'h17);
    for (int k = 0; k < 2; k++) begin
      drv <= 1'b1;
      bt <= 1'b0;
      flt <= (k == 1);
      cyc(2);
      rd(8'h10, 32'h1);
      wdt <= (k == 0);
      bro <= (k == 1);
      cyc(1);
      wdt <= 1'b0;
      bro <= 1'b0;
      cyc(1);
      while (run !== 1'b1) cyc(1);
      drv <= 1'b0;
      rd(8'h08, (k == 1) ? 32'h35 : 32'h36);
    end
    on <= 1'b0;
    cyc(3);
    rd(8'h08, 32'h0);
    while (q.size() != 0) cyc(1);
    give_verdict();
  end
endmodule : boot_strap_latch_and_enable_test
